// File: pkg/rff_consts.svh
`ifndef RFF_CONSTS_SVH
`define RFF_CONSTS_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define RFF_OFS_CTRL      8'h00
`define RFF_OFS_STATUS    8'h04
`define RFF_OFS_MASK      8'h08
`define RFF_OFS_MAC_LO    8'h0c
`define RFF_OFS_MAC_HI    8'h10
`define RFF_OFS_TMO       8'h14
`define RFF_OFS_BC_LIM    8'h18
`define RFF_OFS_MC_LIM    8'h1c
`define RFF_OFS_BC_CNT    8'h20
`define RFF_OFS_MC_CNT    8'h24
`define RFF_OFS_INFO      8'h28
// ****************************************************************
// control bits
// ****************************************************************
`define RFF_CTRL_RING_EN  0
`define RFF_CTRL_TMO_GO   1
`define RFF_CTRL_TMO_IRQ  2
`define RFF_CTRL_STORM_EN 3
`define RFF_CTRL_CNT_CLR  4
// ****************************************************************
// status and mask bits
// ****************************************************************
`define RFF_EV_W          7
`define RFF_EV_QREADY     0
`define RFF_EV_TMO0       1
`define RFF_EV_TMO1       2
`define RFF_EV_LOOP0      3
`define RFF_EV_LOOP1      4
`define RFF_EV_LINK0      5
`define RFF_EV_LINK1      6
`define RFF_EV_LOW_SET    7'h01
`define RFF_EV_TMO_SET    7'h06
// ****************************************************************
// addresses and reset values
// ****************************************************************
`define RFF_MAC_BEACON    48'h01216c000001
`define RFF_MAC_NEIGH     48'h01216c000002
`define RFF_MAC_RING3     48'h01216c000003
`define RFF_MAC_RING4     48'h01216c000004
`define RFF_MAC_RING5     48'h01216c000005
`define RFF_MAC_BCAST     48'hffffffffffff
`define RFF_MAC_GROUP_BIT 40
`define RFF_RST_LIMIT     32'h0000ffff
`define RFF_RST_TMO       32'h0004c4b4
`endif

// File: pkg/rff_pkg.sv
package rff_pkg;
   // frame header handed over by the port parser, one cycle per frame
   typedef struct packed {
      logic        valid;
      logic        port;
      logic        is_ring;
      logic [47:0] dst;
      logic [47:0] src;
      logic [7:0]  ring_state;
      logic [47:0] sup_mac;
   } rff_frame_type;

   // forwarding decision for that frame
   typedef struct packed {
      logic valid;
      logic port;
      logic fwd_other;
      logic to_ring_q;
      logic drop;
   } rff_dec_type;

   typedef enum logic [3:0] {
      RFF_CLS_NONE   = 4'h1,
      RFF_CLS_BEACON = 4'h2,
      RFF_CLS_HOST   = 4'h4,
      RFF_CLS_BOTH   = 4'h8
   } rff_cls_type;
endpackage

// File: verilog/rff_ring_frame_filter.sv
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rff_consts.svh"
module rff_ring_frame_filter
   import rff_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int TMO_W = 32
) (
   input  wire logic          i_mclk,
   input  wire logic          i_rst,
   input  wire logic [7:0]    i_address,
   input  wire logic          i_read,
   input  wire logic          i_write,
   input  wire logic [31:0]   i_writedata,
   input  wire logic [3:0]    i_byteenable,
   output logic      [31:0]   o_readdata,
   output logic               o_waitrequest,
   input  wire rff_frame_type i_frame,
   input  wire logic [1:0]    i_link_up,
   output rff_dec_type        o_dec,
   output logic               o_irq_low,
   output logic               o_irq_med
);
   if (CNT_W < 1 || CNT_W > 32 || TMO_W < 2 || TMO_W > 32) begin : g_bad_w
      $error("rff: CNT_W must be 1..32 and TMO_W 2..32");
   end

   typedef struct packed {
      logic                       wreq;
      logic [31:0]                rdata;
      logic                       ring_en;
      logic                       tmo_go;
      logic                       tmo_irq_en;
      logic                       storm_en;
      logic [47:0]                sysmac;
      logic [TMO_W-1:0]           tmo_lim;
      logic [CNT_W-1:0]           bc_lim;
      logic [CNT_W-1:0]           mc_lim;
      logic [CNT_W-1:0]           bc_cnt;
      logic [CNT_W-1:0]           mc_cnt;
      logic [`RFF_EV_W-1:0]       status;
      logic [`RFF_EV_W-1:0]       mask;
      logic                       seen;
      logic [7:0]                 last_state;
      logic [47:0]                last_sup;
      logic [1:0]                 pend;
      logic [1:0][TMO_W-1:0]      tmo_cnt;
      logic [1:0]                 tmo_hit;
      logic [1:0]                 link_s1;
      logic [1:0]                 link_s2;
      logic [1:0]                 link_q;
      rff_dec_type                dec;
      logic                       irq_low;
      logic                       irq_med;
   } rff_state_type;

   rff_state_type s_reg;
   rff_state_type s_next;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   logic              req;
   logic              wr_now;
   logic [31:0]       wval;
   logic [31:0]       ctrl_w;
   logic [`RFF_EV_W-1:0] ev;
   logic [`RFF_EV_W-1:0] w1c;
   logic              cnt_clr;
   logic              ring;
   logic              bcast;
   logic              mcast;
   logic              loop_hit;
   logic              changed;
   logic [CNT_W-1:0]  bc_c;
   logic [CNT_W-1:0]  mc_c;
   rff_cls_type       cls;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      s_next  = s_reg;
      req     = i_read | i_write;
      wr_now  = i_write & ~s_reg.wreq;
      ev      = '0;
      w1c     = '0;
      cnt_clr = 1'b0;
      ctrl_w  = '0;
      wval    = '0;
      changed = 1'b0;
      cls     = RFF_CLS_NONE;

      // ---- bus slave: one wait cycle, then accept
      s_next.wreq = ~(req & s_reg.wreq);
      if (req & s_reg.wreq) begin
         case (i_address)
            `RFF_OFS_CTRL: begin
               s_next.rdata = {28'h0000000, s_reg.storm_en,
                               s_reg.tmo_irq_en, s_reg.tmo_go,
                               s_reg.ring_en};
            end
            `RFF_OFS_STATUS: s_next.rdata = 32'(s_reg.status);
            `RFF_OFS_MASK:   s_next.rdata = 32'(s_reg.mask);
            `RFF_OFS_MAC_LO: s_next.rdata = s_reg.sysmac[31:0];
            `RFF_OFS_MAC_HI: s_next.rdata = {16'h0000, s_reg.sysmac[47:32]};
            `RFF_OFS_TMO:    s_next.rdata = 32'(s_reg.tmo_lim);
            `RFF_OFS_BC_LIM: s_next.rdata = 32'(s_reg.bc_lim);
            `RFF_OFS_MC_LIM: s_next.rdata = 32'(s_reg.mc_lim);
            `RFF_OFS_BC_CNT: s_next.rdata = 32'(s_reg.bc_cnt);
            `RFF_OFS_MC_CNT: s_next.rdata = 32'(s_reg.mc_cnt);
            `RFF_OFS_INFO: begin
               s_next.rdata = {16'h0000, 2'b00, s_reg.pend,
                               2'b00, s_reg.link_q, s_reg.last_state};
            end
            default:         s_next.rdata = '0;
         endcase
      end
      if (wr_now) begin
         case (i_address)
            `RFF_OFS_CTRL: begin
               ctrl_w = merge(32'h0, i_writedata, i_byteenable);
               s_next.ring_en    = ctrl_w[`RFF_CTRL_RING_EN];
               s_next.tmo_irq_en = ctrl_w[`RFF_CTRL_TMO_IRQ];
               s_next.storm_en   = ctrl_w[`RFF_CTRL_STORM_EN];
               // start is sticky: a second start does not restart
               s_next.tmo_go = s_reg.tmo_go | ctrl_w[`RFF_CTRL_TMO_GO];
               cnt_clr = ctrl_w[`RFF_CTRL_CNT_CLR];
            end
            `RFF_OFS_STATUS: begin
               wval = merge(32'h0, i_writedata, i_byteenable);
               w1c  = wval[`RFF_EV_W-1:0];
            end
            `RFF_OFS_MASK: begin
               wval = merge(32'(s_reg.mask), i_writedata, i_byteenable);
               s_next.mask = wval[`RFF_EV_W-1:0];
            end
            `RFF_OFS_MAC_LO: begin
               s_next.sysmac[31:0] =
                  merge(s_reg.sysmac[31:0], i_writedata, i_byteenable);
            end
            `RFF_OFS_MAC_HI: begin
               wval = merge({16'h0000, s_reg.sysmac[47:32]},
                            i_writedata, i_byteenable);
               s_next.sysmac[47:32] = wval[15:0];
            end
            `RFF_OFS_TMO: begin
               wval = merge(32'(s_reg.tmo_lim), i_writedata, i_byteenable);
               s_next.tmo_lim = wval[TMO_W-1:0];
            end
            `RFF_OFS_BC_LIM: begin
               wval = merge(32'(s_reg.bc_lim), i_writedata, i_byteenable);
               s_next.bc_lim = wval[CNT_W-1:0];
            end
            `RFF_OFS_MC_LIM: begin
               wval = merge(32'(s_reg.mc_lim), i_writedata, i_byteenable);
               s_next.mc_lim = wval[CNT_W-1:0];
            end
            default: begin
            end
         endcase
      end
      if (!s_next.ring_en) begin
         s_next.tmo_go = 1'b0;
      end

      // ---- link pins: two-stage sync, then edge compare
      s_next.link_s1 = i_link_up;
      s_next.link_s2 = s_reg.link_s1;
      s_next.link_q  = s_reg.link_s2;
      ev[`RFF_EV_LINK0] = s_reg.link_s2[0] ^ s_reg.link_q[0];
      ev[`RFF_EV_LINK1] = s_reg.link_s2[1] ^ s_reg.link_q[1];

      // ---- frame classification
      ring  = i_frame.valid & i_frame.is_ring & s_reg.ring_en;
      bcast = i_frame.dst == `RFF_MAC_BCAST;
      mcast = i_frame.dst[`RFF_MAC_GROUP_BIT] & ~bcast;
      loop_hit = i_frame.valid & s_reg.ring_en
               & (i_frame.src == s_reg.sysmac);
      if (ring) begin
         if (i_frame.dst == `RFF_MAC_BEACON) begin
            cls = RFF_CLS_BEACON;
         end else if (i_frame.dst == `RFF_MAC_NEIGH) begin
            cls = RFF_CLS_HOST;
         end else if (i_frame.dst == `RFF_MAC_RING3
                   || i_frame.dst == `RFF_MAC_RING4
                   || i_frame.dst == `RFF_MAC_RING5
                   || (s_reg.seen && i_frame.dst == s_reg.last_sup)) begin
            cls = RFF_CLS_BOTH;
         end
      end

      bc_c = cnt_clr ? '0 : s_reg.bc_cnt;
      mc_c = cnt_clr ? '0 : s_reg.mc_cnt;
      s_next.bc_cnt = bc_c;
      s_next.mc_cnt = mc_c;

      s_next.dec       = '0;
      s_next.dec.valid = i_frame.valid;
      s_next.dec.port  = i_frame.port;
      case (cls)
         RFF_CLS_BEACON: begin
            s_next.dec.fwd_other = 1'b1;
            changed = ~s_reg.seen
                    | (i_frame.ring_state != s_reg.last_state)
                    | (i_frame.sup_mac != s_reg.last_sup);
            if (changed) begin
               s_next.pend = 2'b11;
            end
            s_next.seen       = 1'b1;
            s_next.last_state = i_frame.ring_state;
            s_next.last_sup   = i_frame.sup_mac;
            if (changed | s_reg.pend[i_frame.port]) begin
               s_next.dec.to_ring_q = 1'b1;
               s_next.pend[i_frame.port] = 1'b0;
            end
         end
         RFF_CLS_HOST: begin
            s_next.dec.to_ring_q = 1'b1;
         end
         RFF_CLS_BOTH: begin
            s_next.dec.fwd_other = 1'b1;
            s_next.dec.to_ring_q = 1'b1;
         end
         RFF_CLS_NONE: begin
            s_next.dec.fwd_other = i_frame.valid & ~ring;
            if (i_frame.valid && s_reg.storm_en && bcast) begin
               if (bc_c >= s_reg.bc_lim) begin
                  s_next.dec.drop      = 1'b1;
                  s_next.dec.fwd_other = 1'b0;
               end else begin
                  s_next.bc_cnt = bc_c + 1'b1;
               end
            end
            if (i_frame.valid && s_reg.storm_en && mcast) begin
               if (mc_c >= s_reg.mc_lim) begin
                  s_next.dec.drop      = 1'b1;
                  s_next.dec.fwd_other = 1'b0;
               end else begin
                  s_next.mc_cnt = mc_c + 1'b1;
               end
            end
         end
         default: begin
         end
      endcase
      if (loop_hit) begin
         s_next.dec.fwd_other = 1'b0;
         ev[`RFF_EV_LOOP0 + 32'(i_frame.port)] = 1'b1;
      end
      ev[`RFF_EV_QREADY] = s_next.dec.to_ring_q;
      if (!s_reg.ring_en) begin
         s_next.seen = 1'b0;
         s_next.pend = 2'b00;
      end

      // ---- per-port beacon timeout
      for (int p = 0; p < 2; p++) begin
         if (!s_reg.tmo_go) begin
            s_next.tmo_cnt[p] = '0;
            s_next.tmo_hit[p] = 1'b0;
         end else if (cls == RFF_CLS_BEACON && i_frame.port == 1'(p)) begin
            s_next.tmo_cnt[p] = '0;
            s_next.tmo_hit[p] = 1'b0;
         end else if (!s_reg.tmo_hit[p]) begin
            if (s_reg.tmo_cnt[p] >= s_reg.tmo_lim) begin
               s_next.tmo_hit[p] = 1'b1;
               ev[`RFF_EV_TMO0 + p] = 1'b1;
            end else begin
               s_next.tmo_cnt[p] = s_reg.tmo_cnt[p] + 1'b1;
            end
         end
      end

      // ---- events: set wins over write-one-to-clear
      s_next.status  = (s_reg.status & ~w1c) | ev;
      s_next.irq_low = |(s_next.status & s_next.mask
                       & `RFF_EV_LOW_SET);
      s_next.irq_med = |(s_next.status & s_next.mask
                       & ~`RFF_EV_LOW_SET
                       & ~(s_next.tmo_irq_en ? 7'h00
                                             : `RFF_EV_TMO_SET));
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         s_reg         <= '0;
         s_reg.wreq    <= 1'b1;
         s_reg.tmo_lim <= TMO_W'(`RFF_RST_TMO);
         s_reg.bc_lim  <= CNT_W'(`RFF_RST_LIMIT);
         s_reg.mc_lim  <= CNT_W'(`RFF_RST_LIMIT);
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_readdata    = s_reg.rdata;
   assign o_waitrequest = s_reg.wreq;
   assign o_dec         = s_reg.dec;
   assign o_irq_low     = s_reg.irq_low;
   assign o_irq_med     = s_reg.irq_med;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   ring_queue_only_a: assert property (
      o_dec.to_ring_q |-> $past(ring))
      else $error("ring queue took a non-ring frame");
   queue_event_a: assert property (
      o_dec.to_ring_q |-> s_reg.status[`RFF_EV_QREADY])
      else $error("ring queue write without ready event");
   disabled_quiet_a: assert property (
      !$past(s_reg.ring_en) |-> !o_dec.to_ring_q
                                && (s_reg.ring_en || !s_reg.tmo_go))
      else $error("ring feature active while disabled");
   beacon_fwd_a: assert property (
      cls == RFF_CLS_BEACON && !loop_hit |=> o_dec.fwd_other)
      else $error("beacon not forwarded");
   neigh_host_a: assert property (
      cls == RFF_CLS_HOST |=> !o_dec.fwd_other && o_dec.to_ring_q)
      else $error("neighbour frame misrouted");
   both_fwd_a: assert property (
      cls == RFF_CLS_BOTH && !loop_hit |=> o_dec.fwd_other
                                         && o_dec.to_ring_q)
      else $error("announce-type frame misrouted");
   beacon_quiet_a: assert property (
      cls == RFF_CLS_BEACON && s_reg.seen && !changed
      && !s_reg.pend[i_frame.port] |=> !o_dec.to_ring_q)
      else $error("unchanged beacon reached host");
   tmo_irq_gate_a: assert property (
      !s_reg.tmo_irq_en && s_reg.mask == `RFF_EV_TMO_SET |-> !o_irq_med)
      else $error("timeout interrupt while gated");
   tmo_event_a: assert property (
      s_reg.tmo_go && !s_reg.tmo_hit[0] && cls != RFF_CLS_BEACON
      && s_reg.tmo_cnt[0] >= s_reg.tmo_lim
      |=> s_reg.status[`RFF_EV_TMO0] && s_reg.tmo_hit[0])
      else $error("port timeout not raised");
   loop_block_a: assert property (
      loop_hit |=> !o_dec.fwd_other
                   && s_reg.status[`RFF_EV_LOOP0 + 32'(o_dec.port)])
      else $error("looped frame forwarded");
   link_event_a: assert property (
      $rose(s_reg.link_s2[0]) |=> s_reg.status[`RFF_EV_LINK0])
      else $error("link change not reported");
   storm_drop_a: assert property (
      s_reg.storm_en && !cnt_clr && cls == RFF_CLS_NONE && i_frame.valid
      && bcast && s_reg.bc_cnt >= s_reg.bc_lim |=> o_dec.drop)
      else $error("broadcast beyond limit accepted");
   clr_both_a: assert property (
      cnt_clr && !i_frame.valid |=> s_reg.bc_cnt == '0
                                    && s_reg.mc_cnt == '0)
      else $error("counter clear missed a counter");
   wait_one_a: assert property (
      req && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
      else $error("bus answer not one cycle");
endmodule

// File: sim/rff_host_model.sv
`timescale 1ns/1ps
`include "rff_consts.svh"
module rff_host_model
   import rff_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_waitrequest,
   input  wire logic [31:0] i_readdata,
   output logic      [7:0]  o_address,
   output logic             o_read,
   output logic             o_write,
   output logic      [31:0] o_writedata,
   output logic      [3:0]  o_byteenable
);
   initial begin
      o_address = 8'h00;
      o_read = 1'b0;
      o_write = 1'b0;
      o_writedata = 32'h0;
      o_byteenable = 4'hf;
   end
   // ****************************************************************
   // bus cycles, held until waitrequest seen low
   // ****************************************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      o_address <= a;
      o_writedata <= d;
      o_write <= 1'b1;
      do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
      o_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_mclk);
      o_address <= a;
      o_read <= 1'b1;
      do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
      d = i_readdata;
      o_read <= 1'b0;
   endtask
   // ****************************************************************
   // driver calls
   // ****************************************************************
   task automatic ring_on();
      wr(`RFF_OFS_CTRL, 32'h1);
   endtask
   task automatic start_tmo(input logic [31:0] lim);
      wr(`RFF_OFS_TMO, lim);
      wr(`RFF_OFS_CTRL, 32'h3);
   endtask
   task automatic tmo_irq_on();
      wr(`RFF_OFS_CTRL, 32'h7);
   endtask
   task automatic storm_clear(input logic [31:0] keep);
      wr(`RFF_OFS_CTRL, keep | 32'h10);
   endtask
endmodule

// File: sim/tb_ring_frame_filter.sv
`timescale 1ns/1ps
`include "rff_consts.svh"
module tb_ring_frame_filter
   import rff_pkg::*;
;
   localparam logic [47:0] SUP = 48'h020b0c0d0e0f;
   localparam logic [47:0] UNI = 48'h020000001234;
   localparam logic [47:0] MCA = 48'h030000000001;
   logic          i_mclk = 1'b0;
   logic          i_rst = 1'b1;
   logic [7:0]    av_addr;
   logic          av_rd;
   logic          av_wr;
   logic [31:0]   av_wdata;
   logic [3:0]    av_be;
   logic [31:0]   av_rdata;
   logic          av_wait;
   rff_frame_type i_frame;
   logic [1:0]    i_link_up;
   rff_dec_type   o_dec;
   logic          irq_low;
   logic          irq_med;
   rff_dec_type   exp_q[$];
   logic [4:0]    care_q[$];
   int            n_errors = 0;
   int            comparisons = 0;
   int            cycles = 0;
   logic [15:0]   lfsr = 16'h0f41;
   logic [47:0]   sup_v = SUP;
   logic [47:0]   dsts[6];
   logic [1:0]    fq[6];
   always #2 i_mclk = ~i_mclk;
   rff_ring_frame_filter #(.CNT_W(16), .TMO_W(32)) rff_ring_frame_filter_inst (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_address(av_addr), .i_read(av_rd),
      .i_write(av_wr), .i_writedata(av_wdata), .i_byteenable(av_be),
      .o_readdata(av_rdata), .o_waitrequest(av_wait), .i_frame(i_frame),
      .i_link_up(i_link_up), .o_dec(o_dec), .o_irq_low(irq_low),
      .o_irq_med(irq_med));
   rff_host_model rff_host_model_inst (
      .i_mclk(i_mclk), .i_waitrequest(av_wait), .i_readdata(av_rdata),
      .o_address(av_addr), .o_read(av_rd), .o_write(av_wr),
      .o_writedata(av_wdata), .o_byteenable(av_be));
   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [47:0] rsrc();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return {32'h02000000, lfsr};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_dec(input rff_dec_type e, input logic [4:0] c,
                          input rff_dec_type g);
      comparisons++;
      if ((g & c) !== (e & c)) begin
         n_errors++;
         $display("Error decision expected %h seen %h", e, g);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      rff_host_model_inst.wr(a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e, input string nm);
      logic [31:0] v;
      rff_host_model_inst.rd(a, v);
      chk(nm, e, v & m);
   endtask
   // expected bits are fwd_other, to_ring_q, drop
   task automatic send(input logic p, input logic ring, input logic [47:0] d,
                       input logic [47:0] s, input logic [7:0] st,
                       input logic [2:0] e, input logic [2:0] c);
      @(posedge i_mclk);
      i_frame <= '{1'b1, p, ring, d, s, st, sup_v};
      exp_q.push_back(rff_dec_type'({1'b1, p, e}));
      care_q.push_back({2'b11, c});
      @(posedge i_mclk);
      i_frame.valid <= 1'b0;
   endtask
   task automatic stop_test();
      chk("pending decisions", 32'h0, 32'(exp_q.size()));
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ****************************************************************
   // decision monitor and timeout
   // ****************************************************************
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         stop_test();
      end else if (o_dec.valid === 1'b1) begin
         if (exp_q.size() == 0)
            chk("decision count", 32'h0, 32'h1);
         else
            chk_dec(exp_q.pop_front(), care_q.pop_front(), o_dec);
      end
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      i_frame = '0;
      i_link_up = 2'b00;
      dsts = '{`RFF_MAC_BEACON, `RFF_MAC_NEIGH, `RFF_MAC_RING3,
               `RFF_MAC_RING4, `RFF_MAC_RING5, SUP};
      fq = '{2'b11, 2'b01, 2'b11, 2'b11, 2'b11, 2'b11};
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      rchk(`RFF_OFS_CTRL, 32'hffffffff, 32'h0, "ctrl");
      rchk(`RFF_OFS_BC_LIM, 32'hffffffff, `RFF_RST_LIMIT, "bc limit");
      send(0, 1, `RFF_MAC_BEACON, rsrc(), 8'h01, 3'b000, 3'b010);
      rchk(`RFF_OFS_STATUS, 32'hffffffff, 32'h0, "status off");
      w(`RFF_OFS_MASK, 32'h7f);
      rff_host_model_inst.ring_on();
      for (int i = 0; i < 6; i++)
         send(0, 1, dsts[i], rsrc(), 8'h01, {fq[i], 1'b0}, 3'b111);
      repeat (2) @(posedge i_mclk);
      chk("low irq", 32'h1, {31'h0, irq_low});
      rchk(`RFF_OFS_STATUS, 32'h1, 32'h1, "queue event");
      for (int i = 0; i < 6; i++)
         send(1'(6'b110101 >> i), 1, `RFF_MAC_BEACON, rsrc(),
              (i < 3) ? 8'h01 : 8'h02,
              {1'b1, 1'((6'b011001 >> i) & 1), 1'b0}, 3'b110);
      w(`RFF_OFS_STATUS, 32'h7f);
      rchk(`RFF_OFS_STATUS, 32'h1, 32'h0, "queue clear");
      chk("low irq off", 32'h0, {31'h0, irq_low});
      send(0, 0, UNI, rsrc(), 8'h00, 3'b000, 3'b010);
      w(`RFF_OFS_MAC_LO, 32'h00000001);
      w(`RFF_OFS_MAC_HI, 32'h000002aa);
      send(1, 0, UNI, 48'h02aa00000001, 8'h00, 3'b000, 3'b100);
      rchk(`RFF_OFS_STATUS, 32'h18, 32'h10, "loop event");
      chk("med irq loop", 32'h1, {31'h0, irq_med});
      for (int i = 0; i < 2; i++) begin
         w(`RFF_OFS_STATUS, 32'h7f);
         @(posedge i_mclk);
         i_link_up <= i_link_up ^ 2'b01;
         repeat (6) @(posedge i_mclk);
         rchk(`RFF_OFS_STATUS, 32'h60, 32'h20, "link event");
      end
      w(`RFF_OFS_STATUS, 32'h7f);
      w(`RFF_OFS_MASK, 32'(`RFF_EV_TMO_SET));
      rff_host_model_inst.start_tmo(32'd20);
      repeat (30) @(posedge i_mclk);
      rchk(`RFF_OFS_STATUS, 32'h6, 32'h6, "timeouts");
      chk("med irq gated", 32'h0, {31'h0, irq_med});
      rff_host_model_inst.tmo_irq_on();
      repeat (2) @(posedge i_mclk);
      chk("med irq tmo", 32'h1, {31'h0, irq_med});
      w(`RFF_OFS_STATUS, 32'h6);
      send(0, 1, `RFF_MAC_BEACON, rsrc(), 8'h02, 3'b100, 3'b100);
      rchk(`RFF_OFS_STATUS, 32'h6, 32'h0, "tmo rearm");
      repeat (30) @(posedge i_mclk);
      rchk(`RFF_OFS_STATUS, 32'h6, 32'h2, "tmo port");
      sup_v = UNI;
      send(1, 1, `RFF_MAC_BEACON, rsrc(), 8'h02, 3'b110, 3'b110);
      w(`RFF_OFS_MASK, 32'h0);
      w(`RFF_OFS_BC_LIM, 32'd3);
      w(`RFF_OFS_MC_LIM, 32'd2);
      w(`RFF_OFS_CTRL, 32'h0f);
      for (int i = 0; i < 7; i++)
         send(0, 0, i[0] ? MCA : `RFF_MAC_BCAST, rsrc(), 8'h00,
              {2'b00, 1'(i > 4)}, 3'b001);
      rff_host_model_inst.storm_clear(32'h0f);
      send(0, 0, `RFF_MAC_BCAST, rsrc(), 8'h00, 3'b000, 3'b001);
      send(1, 0, MCA, rsrc(), 8'h00, 3'b000, 3'b001);
      rchk(`RFF_OFS_BC_CNT, 32'hffffffff, 32'h1, "bc count");
      rchk(`RFF_OFS_MC_CNT, 32'hffffffff, 32'h1, "mc count");
      repeat (3) @(posedge i_mclk);
      stop_test();
   end
endmodule
